/* logic/fmm_core.sv */
// Float sign-transfer/min/max/magnitude-limit and fixed multiply/MAC slice with AXI4-Lite
// registers. Assumes one clock, synchronous reset, and a master that keeps AXI4-Lite rules.
`timescale 1ns/1ns

// Function
// - Sign transfer keeps x magnitude, y sign
// - Denormal inputs flush to signed zero
// - Any NaN input yields all ones
// - Smaller-select; minus zero beats plus zero
// - Larger-select; plus zero beats minus zero
// - Limit x magnitude to y magnitude
// - Zero, negative set; overflow, carry, shift cleared
// - ALU invalid follows NaN input
// - Invalid sticky set by invalid, others kept
// - Options: x, y signedness, format, rounding
// - Round only fractional when requested
// - Data register gets matching product part
// - Extension bits cleared on data write
// - Accumulator receives full 80 bits
// - MAC adds product to selected accumulator
// - Product negative follows sign, invalid cleared
// - Product overflow from upper bit check
// - Fractional underflow check, never integer
// - Overflow sticky from overflow, others kept
module fmm_core
  import fmm_pkg::*;
(
  input  wire logic          MCLK_IN,
  input  wire logic          RST_IN,
  input  wire fmm_axil_req_t AXI_REQ_IN,
  output fmm_axil_rsp_t      AXI_RSP_OUT
);

  fmm_state_t st;
  fmm_state_t next_st;

  function automatic logic is_nan(input logic [31:0] f);
    is_nan = (f[30:23] == 8'hFF) && (f[22:0] != 23'h0);
  endfunction

  function automatic logic [31:0] flush(input logic [31:0] f);
    if ((f[30:23] == 8'h00) && (f[22:0] != 23'h0)) begin
      flush = {f[31], 31'h0};
    end else begin
      flush = f;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // Operation decode from the control register
  logic [2:0] op_code;
  logic       op_float;
  logic       op_fixed;
  logic       op_mac;

  always_comb begin
    op_code  = st.ctrl[CTRL_OP_LSB +: 3];
    op_float = op_code <= OP_MAGNITUDE_LIMIT;
    op_fixed = (op_code == OP_MULTIPLY) || (op_code == OP_MAC);
    op_mac   = op_code == OP_MAC;
  end

  // Float datapath
  logic [31:0] flushed_x;
  logic [31:0] flushed_y;
  logic        any_nan;
  logic        signs_differ;
  logic        x_smaller_mag;
  logic [31:0] sign_xfer_res;
  logic [31:0] smaller_res;
  logic [31:0] larger_res;
  logic [31:0] limit_res;
  logic [31:0] f_result;

  // Flushed operands feed every comparison, so a denormal never wins on magnitude
  always_comb begin
    flushed_x     = flush(st.opx);
    flushed_y     = flush(st.opy);
    any_nan       = is_nan(st.opx) || is_nan(st.opy);
    signs_differ  = flushed_x[31] != flushed_y[31];
    x_smaller_mag = flushed_x[30:0] < flushed_y[30:0];
  end

  // Exponent and mantissa fields order two magnitudes the way integers do
  always_comb begin
    if (signs_differ) begin
      smaller_res = flushed_x[31] ? flushed_x : flushed_y;
      larger_res  = flushed_x[31] ? flushed_y : flushed_x;
    end else if (flushed_x[31]) begin
      smaller_res = x_smaller_mag ? flushed_y : flushed_x;
      larger_res  = x_smaller_mag ? flushed_x : flushed_y;
    end else begin
      smaller_res = x_smaller_mag ? flushed_x : flushed_y;
      larger_res  = x_smaller_mag ? flushed_y : flushed_x;
    end
  end

  always_comb begin
    sign_xfer_res = {flushed_y[31], flushed_x[30:0]};
    if (x_smaller_mag) begin
      limit_res = flushed_x;
    end else begin
      limit_res = {flushed_x[31], flushed_y[30:0]};
    end
  end

  always_comb begin
    unique case (op_code)
      OP_SIGN_TRANSFER: f_result = sign_xfer_res;
      OP_SMALLER:       f_result = smaller_res;
      OP_LARGER:        f_result = larger_res;
      default:          f_result = limit_res;
    endcase
    if (any_nan) begin
      f_result = 32'hFFFF_FFFF;
    end
  end

  // Fixed-point datapath
  logic        x_signed;
  logic        y_signed;
  logic        frac;
  logic        rnd;
  logic        res_signed;
  logic [79:0] x_ext;
  logic [79:0] y_ext;
  logic [79:0] product;
  logic [79:0] addend;
  logic [79:0] m_sum;
  logic [79:0] m_final;
  logic        ovf_sfrac;
  logic        ovf_sint;
  logic        ovf_ufrac;
  logic        ovf_uint;
  logic        m_ovf;
  logic        unf_low_set;
  logic        unf_high_zero;
  logic        unf_high_ones;
  logic        m_unf;

  // A result is signed when either operand is; each operand widens by its own option
  always_comb begin
    x_signed   = st.ctrl[CTRL_XSIGNED];
    y_signed   = st.ctrl[CTRL_YSIGNED];
    frac       = st.ctrl[CTRL_FRAC];
    rnd        = st.ctrl[CTRL_ROUND];
    res_signed = x_signed || y_signed;
    x_ext      = x_signed ? {{48{st.opx[31]}}, st.opx} : {48'h0, st.opx};
    y_ext      = y_signed ? {{48{st.opy[31]}}, st.opy} : {48'h0, st.opy};
  end

  // Fractional products shift once so the binary point sits at bit 63
  always_comb begin
    product = x_ext * y_ext;
    if (frac) begin
      product = {product[78:0], 1'b0};
    end
    addend = st.ctrl[CTRL_ACC_SEL] ? st.acc_back : st.acc_fore;
    if (op_mac) begin
      m_sum = addend + product;
    end else begin
      m_sum = product;
    end
  end

  // Round half up at the word boundary; integer results pass untouched
  always_comb begin
    m_final = m_sum;
    if (frac && rnd) begin
      m_final       = m_sum + ROUND_ADD;
      m_final[31:0] = 32'h0;
    end
  end

  // Upper bits must all match the sign, over a width set by format and signedness
  always_comb begin
    ovf_sfrac = !((&m_final[79:OVF_SFRAC_LSB]) || !(|m_final[79:OVF_SFRAC_LSB]));
    ovf_sint  = !((&m_final[79:OVF_SINT_LSB]) || !(|m_final[79:OVF_SINT_LSB]));
    ovf_ufrac = |m_final[79:OVF_UFRAC_LSB];
    ovf_uint  = |m_final[79:OVF_UINT_LSB];
    unique case ({res_signed, frac})
      2'h3: m_ovf = ovf_sfrac;
      2'h2: m_ovf = ovf_sint;
      2'h1: m_ovf = ovf_ufrac;
      2'h0: m_ovf = ovf_uint;
    endcase
  end

  always_comb begin
    unf_low_set   = |m_final[UNF_LSB-1:0];
    unf_high_zero = !(|m_final[79:UNF_LSB]);
    unf_high_ones = res_signed && (&m_final[79:UNF_LSB]);
    m_unf         = frac && unf_low_set && (unf_high_zero || unf_high_ones);
  end

  // Register read mux
  logic        rd_hit;
  logic [31:0] rd_data;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0;
    unique case (AXI_REQ_IN.araddr)
      REG_CTRL:      rd_data = {16'h0, st.ctrl};
      REG_OPX:       rd_data = st.opx;
      REG_OPY:       rd_data = st.opy;
      REG_RESULT:    rd_data = st.result[31:0];
      REG_RESULT_EX: rd_data = {24'h0, st.result[39:32]};
      REG_STATUS:    rd_data = {16'h0, st.status};
      REG_STICKY:    rd_data = {16'h0, st.sticky};
      REG_FORE_LO:   rd_data = st.acc_fore[31:0];
      REG_FORE_MID:  rd_data = st.acc_fore[63:32];
      REG_FORE_HI:   rd_data = {16'h0, st.acc_fore[79:64]};
      REG_BACK_LO:   rd_data = st.acc_back[31:0];
      REG_BACK_MID:  rd_data = st.acc_back[63:32];
      REG_BACK_HI:   rd_data = {16'h0, st.acc_back[79:64]};
      default:       rd_hit  = 1'b0;
    endcase
  end

  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_write;
  logic [31:0] wr_val;
  logic [15:0] sticky_set;
  logic [15:0] sticky_base;
  logic        is_float_op;
  logic        is_fixed_op;
  logic        dest_acc;

  always_comb begin
    next_st = st;
    aw_take = AXI_REQ_IN.awvalid && !st.aw_held && !st.bvalid;
    w_take  = AXI_REQ_IN.wvalid && !st.w_held && !st.bvalid;
    ar_take = AXI_REQ_IN.arvalid && !st.rvalid;

    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = AXI_REQ_IN.awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = AXI_REQ_IN.wdata;
      next_st.wstrb  = AXI_REQ_IN.wstrb;
    end
    if (st.bvalid && AXI_REQ_IN.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && AXI_REQ_IN.rready) begin
      next_st.rvalid = 1'b0;
    end
    // Read data is latched as the address is taken, so it stands until rready
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_data;
      next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Execute an operation one cycle after its control write
    next_st.go  = 1'b0;
    // Codes 6 and 7 start nothing: results, flags and accumulators keep their values
    is_float_op = st.go && op_float;
    is_fixed_op = st.go && op_fixed;
    dest_acc    = st.ctrl[CTRL_DEST_ACC];
    sticky_set  = 16'h0;
    if (is_float_op) begin
      next_st.result = {8'h0, f_result};
      next_st.status[ALU_ZERO_FLAG]     = f_result[30:0] == 31'h0;
      next_st.status[ALU_NEGATIVE_FLAG] = f_result[31];
      next_st.status[ALU_OVERFLOW_FLAG] = 1'b0;
      next_st.status[ALU_CARRY_FLAG]    = 1'b0;
      next_st.status[ALU_SHIFT_FLAG]    = 1'b0;
      next_st.status[ALU_INVALID_FLAG]  = any_nan;
      sticky_set[ALU_INVALID_STICKY]    = any_nan;
    end
    if (is_fixed_op) begin
      if (dest_acc) begin
        // Destination accumulator is the one that gave the addend
        if (st.ctrl[CTRL_ACC_SEL]) begin
          next_st.acc_back = m_final;
        end else begin
          next_st.acc_fore = m_final;
        end
      end else if (frac) begin
        next_st.result = {8'h00, m_final[FRAC_HI_LSB +: 32]};
      end else begin
        next_st.result = {8'h00, m_final[31:0]};
      end
      next_st.status[PRODUCT_NEGATIVE_FLAG]  = res_signed && m_final[79];
      next_st.status[PRODUCT_OVERFLOW_FLAG]  = m_ovf;
      next_st.status[PRODUCT_UNDERFLOW_FLAG] = m_unf;
      next_st.status[PRODUCT_INVALID_FLAG]   = 1'b0;
      sticky_set[PRODUCT_OVERFLOW_STICKY]    = m_ovf;
    end

    // Register write, one word per aligned offset
    do_write    = st.aw_held && st.w_held && !st.bvalid;
    sticky_base = st.sticky;
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      unique case (st.awaddr)
        REG_CTRL: begin
          // Operands must already stand in OPX and OPY when the control word lands
          wr_val       = merge({16'h0, st.ctrl}, st.wdata, st.wstrb);
          next_st.ctrl = wr_val[15:0] & CTRL_MASK;
          next_st.go   = 1'b1;
        end
        REG_OPX: begin
          wr_val      = merge(st.opx, st.wdata, st.wstrb);
          next_st.opx = wr_val;
        end
        REG_OPY: begin
          wr_val      = merge(st.opy, st.wdata, st.wstrb);
          next_st.opy = wr_val;
        end
        REG_STICKY: begin
          wr_val      = merge({16'h0, st.sticky}, st.wdata, st.wstrb);
          sticky_base = wr_val[15:0] & STICKY_MASK;
        end
        REG_RESULT, REG_RESULT_EX, REG_STATUS, REG_FORE_LO, REG_FORE_MID, REG_FORE_HI,
        REG_BACK_LO, REG_BACK_MID, REG_BACK_HI: begin
          wr_val = 32'h0;
        end
        default: begin
          wr_val        = 32'h0;
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end else begin
      wr_val = 32'h0;
    end
    // Hardware set wins over a software write in the same cycle
    next_st.sticky = sticky_base | sticky_set;
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      st        <= '0;
      st.ctrl   <= CTRL_RESET;
      st.status <= STATUS_RESET;
      st.sticky <= STICKY_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    AXI_RSP_OUT.awready = !st.aw_held && !st.bvalid;
    AXI_RSP_OUT.wready  = !st.w_held && !st.bvalid;
    AXI_RSP_OUT.bvalid  = st.bvalid;
    AXI_RSP_OUT.bresp   = st.bresp;
    AXI_RSP_OUT.arready = !st.rvalid;
    AXI_RSP_OUT.rvalid  = st.rvalid;
    AXI_RSP_OUT.rdata   = st.rdata;
    AXI_RSP_OUT.rresp   = st.rresp;
  end

endmodule

/* logic/fmm_pkg.sv */
// Constants, register map and carrier types of the float min/max and fixed MAC slice.
// Assumes a single 25 MHz core clock and an AXI4-Lite master with 32-bit data.
package fmm_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_OPX       = 8'h04;
  localparam logic [7:0] REG_OPY       = 8'h08;
  localparam logic [7:0] REG_RESULT    = 8'h0C;
  localparam logic [7:0] REG_RESULT_EX = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_STICKY    = 8'h18;
  localparam logic [7:0] REG_FORE_LO   = 8'h1C;
  localparam logic [7:0] REG_FORE_MID  = 8'h20;
  localparam logic [7:0] REG_FORE_HI   = 8'h24;
  localparam logic [7:0] REG_BACK_LO   = 8'h28;
  localparam logic [7:0] REG_BACK_MID  = 8'h2C;
  localparam logic [7:0] REG_BACK_HI   = 8'h30;

  // Control register fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_XSIGNED  = 4;
  localparam int CTRL_YSIGNED  = 5;
  localparam int CTRL_FRAC     = 6;
  localparam int CTRL_ROUND    = 7;
  localparam int CTRL_DEST_ACC = 8;
  localparam int CTRL_ACC_SEL  = 9;
  localparam logic [15:0] CTRL_MASK = 16'h03F7;

  // Operation codes
  localparam logic [2:0] OP_SIGN_TRANSFER   = 3'h0;
  localparam logic [2:0] OP_SMALLER         = 3'h1;
  localparam logic [2:0] OP_LARGER          = 3'h2;
  localparam logic [2:0] OP_MAGNITUDE_LIMIT = 3'h3;
  localparam logic [2:0] OP_MULTIPLY        = 3'h4;
  localparam logic [2:0] OP_MAC             = 3'h5;

  // Arithmetic status bits
  localparam int ALU_ZERO_FLAG         = 0;
  localparam int ALU_NEGATIVE_FLAG     = 1;
  localparam int ALU_OVERFLOW_FLAG     = 2;
  localparam int ALU_CARRY_FLAG        = 3;
  localparam int ALU_SHIFT_FLAG        = 4;
  localparam int ALU_INVALID_FLAG      = 5;
  localparam int PRODUCT_NEGATIVE_FLAG  = 8;
  localparam int PRODUCT_OVERFLOW_FLAG  = 9;
  localparam int PRODUCT_UNDERFLOW_FLAG = 10;
  localparam int PRODUCT_INVALID_FLAG   = 11;

  // Sticky status bits
  localparam int ALU_UNDERFLOW_STICKY      = 0;
  localparam int ALU_OVERFLOW_STICKY       = 1;
  localparam int ALU_FIXED_OVERFLOW_STICKY = 2;
  localparam int ALU_INVALID_STICKY        = 3;
  localparam int PRODUCT_UNDERFLOW_STICKY   = 8;
  localparam int PRODUCT_FP_OVERFLOW_STICKY = 9;
  localparam int PRODUCT_OVERFLOW_STICKY    = 10;
  localparam int PRODUCT_INVALID_STICKY     = 11;
  localparam logic [15:0] STICKY_MASK = 16'h0F0F;

  // Fixed-point result layout
  localparam int FRAC_HI_LSB   = 32;
  localparam int OVF_SFRAC_LSB = 47;
  localparam int OVF_SINT_LSB  = 31;
  localparam int OVF_UFRAC_LSB = 48;
  localparam int OVF_UINT_LSB  = 32;
  localparam int UNF_LSB       = 32;
  localparam logic [79:0] ROUND_ADD = 80'h0000_0000_0000_8000_0000;

  // AXI4-Lite answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STICKY_RESET = 16'h0000;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } fmm_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fmm_axil_rsp_t;

  typedef struct packed {
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [15:0] ctrl;
    logic        go;
    logic [31:0] opx;
    logic [31:0] opy;
    logic [39:0] result;
    logic [15:0] status;
    logic [15:0] sticky;
    logic [79:0] acc_fore;
    logic [79:0] acc_back;
  } fmm_state_t;

endpackage

/* test/fmm_core_props.sv */
// Bus-level checks of the float min/max and fixed MAC slice.
// Assumes it is bound to fmm_core and sees only its ports.
`timescale 1ns/1ns
module fmm_core_props
  import fmm_pkg::*;
(
  input  wire logic          MCLK_IN,
  input  wire logic          RST_IN,
  input  wire fmm_axil_req_t AXI_REQ_IN,
  input  wire fmm_axil_rsp_t AXI_RSP_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  wire logic ar_go = AXI_REQ_IN.arvalid && AXI_RSP_OUT.arready;
  wire logic wr_go = AXI_REQ_IN.awvalid && AXI_RSP_OUT.awready
                     && AXI_REQ_IN.wvalid && AXI_RSP_OUT.wready;

  property p_wr_answer;
    wr_go |-> ##[1:2] AXI_RSP_OUT.bvalid;
  endproperty
  property p_b_hold;
    AXI_RSP_OUT.bvalid && !AXI_REQ_IN.bready |=> AXI_RSP_OUT.bvalid && $stable(AXI_RSP_OUT.bresp);
  endproperty
  property p_b_done;
    AXI_RSP_OUT.bvalid && AXI_REQ_IN.bready |=> !AXI_RSP_OUT.bvalid;
  endproperty
  property p_b_block;
    AXI_RSP_OUT.bvalid |-> !AXI_RSP_OUT.awready && !AXI_RSP_OUT.wready;
  endproperty
  property p_rd_answer;
    ar_go |=> AXI_RSP_OUT.rvalid;
  endproperty
  property p_r_hold;
    AXI_RSP_OUT.rvalid && !AXI_REQ_IN.rready |=> AXI_RSP_OUT.rvalid && $stable(AXI_RSP_OUT.rdata);
  endproperty
  property p_unmapped;
    ar_go && AXI_REQ_IN.araddr > REG_BACK_HI
      |=> AXI_RSP_OUT.rresp == RESP_SLVERR && AXI_RSP_OUT.rdata == 32'h0;
  endproperty
  property p_status;
    ar_go && AXI_REQ_IN.araddr == REG_STATUS
      |=> AXI_RSP_OUT.rdata[4:2] == 3'h0 && AXI_RSP_OUT.rdata[31:12] == 20'h0;
  endproperty
  property p_sticky;
    ar_go && AXI_REQ_IN.araddr == REG_STICKY
      |=> (AXI_RSP_OUT.rdata[15:0] & ~STICKY_MASK) == 16'h0 && AXI_RSP_OUT.rdata[31:16] == 16'h0;
  endproperty

  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  a_b_done: assert property (p_b_done) else $error("write answer kept");
  a_b_block: assert property (p_b_block) else $error("write taken while answering");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_status: assert property (p_status) else $error("status has stray bits");
  a_sticky: assert property (p_sticky) else $error("sticky has stray bits");

  c_write: cover property (AXI_RSP_OUT.bvalid && AXI_REQ_IN.bready);
  c_refused: cover property (AXI_RSP_OUT.rvalid && AXI_RSP_OUT.rresp == RESP_SLVERR);
  c_status: cover property (ar_go && AXI_REQ_IN.araddr == REG_STATUS);
endmodule

bind fmm_core fmm_core_props i_fmm_core_props (
  .MCLK_IN     (MCLK_IN),
  .RST_IN      (RST_IN),
  .AXI_REQ_IN  (AXI_REQ_IN),
  .AXI_RSP_OUT (AXI_RSP_OUT)
);

/* test/fmm_seq_model.sv */
// Sequencer stand-in: issues one AXI4-Lite register access at a time.
// Assumes the slice shares its clock; all changes follow a rising edge.
`timescale 1ns/1ns
module fmm_seq_model
  import fmm_pkg::*;
(
  input  wire logic          mclk_in,
  input  wire fmm_axil_rsp_t rsp_in,
  output fmm_axil_req_t      req_out
);
  initial req_out = '0;

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    req_out.awvalid <= 1'b1;
    req_out.awaddr  <= a;
    req_out.wvalid  <= 1'b1;
    req_out.wdata   <= d;
    req_out.wstrb   <= 4'hF;
    req_out.bready  <= 1'b1;
    r = 2'h3;
    repeat (100) begin
      @(posedge mclk_in);
      if (req_out.awvalid && rsp_in.awready) begin
        req_out.awvalid <= 1'b0;
        req_out.awaddr  <= ~a;
      end
      if (req_out.wvalid && rsp_in.wready) begin
        req_out.wvalid <= 1'b0;
        req_out.wdata  <= ~d;
      end
      if (rsp_in.bvalid) begin
        r = rsp_in.bresp;
        req_out.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    req_out.arvalid <= 1'b1;
    req_out.araddr  <= a;
    req_out.rready  <= 1'b1;
    r = 2'h3;
    d = 32'h0;
    repeat (100) begin
      @(posedge mclk_in);
      if (req_out.arvalid && rsp_in.arready) begin
        req_out.arvalid <= 1'b0;
        req_out.araddr  <= ~a;
      end
      if (rsp_in.rvalid) begin
        d = rsp_in.rdata;
        r = rsp_in.rresp;
        req_out.rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the float min/max and fixed MAC slice.
// Assumes fmm_seq_model issues the bus cycles and the checker is bound.
`timescale 1ns/1ns
module tb_top import fmm_pkg::*;;
  logic          mclk = 1'b0;
  logic          rst  = 1'b1;
  fmm_axil_req_t req;
  fmm_axil_rsp_t rsp;
  int            err_count = 0;
  int            n_checks  = 0;

  always #20 mclk = ~mclk;

  fmm_core i_fmm_core (.MCLK_IN(mclk), .RST_IN(rst), .AXI_REQ_IN(req), .AXI_RSP_OUT(rsp));
  fmm_seq_model i_fmm_seq_model (.mclk_in(mclk), .rsp_in(rsp), .req_out(req));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    logic [1:0] r;
    i_fmm_seq_model.wr(a, d, r);
    check($sformatf("bresp %h", a), {30'h0, r}, {30'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    i_fmm_seq_model.rd(a, d, r);
    check($sformatf("rresp %h", a), {30'h0, r}, {30'h0, e});
    check($sformatf("rdata %h", a), d, x);
  endtask

  task automatic fl(input logic [15:0] c, input logic [31:0] x, y, r, input logic [15:0] s);
    wr(REG_OPX, x);
    wr(REG_OPY, y);
    wr(REG_CTRL, {16'h0, c});
    rd(REG_RESULT, r);
    rd(REG_STATUS, {16'h0, s});
  endtask

  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(REG_CTRL, {16'h0, CTRL_RESET});
    rd(REG_STATUS, {16'h0, STATUS_RESET});
    rd(REG_STICKY, {16'h0, STICKY_RESET});
    rd(REG_FORE_LO, 32'h0);
    rd(8'h34, 32'h0, RESP_SLVERR);
    wr(8'h34, 32'h1, RESP_SLVERR);
    fl(16'h0000, 32'h3F80_0000, 32'h8000_0000, 32'hBF80_0000, 16'h0002);
    fl(16'h0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 16'h0001);
    for (int k = 0; k < 4; k++)
      fl(16'(k), 32'h3F80_0000, 32'h7FC0_0000, 32'hFFFF_FFFF, 16'h0022);
    rd(REG_STICKY, 32'h0000_0008);
    fl(16'h0001, 32'h7FC0_0000, 32'h3F80_0000, 32'hFFFF_FFFF, 16'h0022);
    fl(16'h0001, 32'h3F80_0000, 32'hC000_0000, 32'hC000_0000, 16'h0002);
    fl(16'h0001, 32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 16'h0003);
    fl(16'h0002, 32'h8000_0000, 32'h0000_0000, 32'h0000_0000, 16'h0001);
    fl(16'h0002, 32'hBF80_0000, 32'h4000_0000, 32'h4000_0000, 16'h0000);
    rd(REG_STICKY, 32'h0000_0008);
    fl(16'h0003, 32'hC040_0000, 32'h4000_0000, 32'hC000_0000, 16'h0002);
    fl(16'h0003, 32'h3F80_0000, 32'hC000_0000, 32'h3F80_0000, 16'h0000);
    wr(REG_STICKY, 32'hFFFF_FFFF);
    rd(REG_STICKY, {16'h0, STICKY_MASK});
    wr(REG_STICKY, 32'h0);
    fl(16'h0004, 32'h5, 32'h7, 32'h23, 16'h0000);
    rd(REG_RESULT_EX, 32'h0);
    fl(16'h0084, 32'h5, 32'h7, 32'h23, 16'h0000);
    fl(16'h0014, 32'hFFFF_FFFE, 32'h3, 32'hFFFF_FFFA, 16'h0100);
    fl(16'h0024, 32'h3, 32'hFFFF_FFFE, 32'hFFFF_FFFA, 16'h0100);
    fl(16'h0004, 32'hFFFF_FFFE, 32'h3, 32'hFFFF_FFFA, 16'h0200);
    fl(16'h0034, 32'h0001_0000, 32'h8000, 32'h8000_0000, 16'h0200);
    fl(16'h0004, 32'h0001_0000, 32'h8000, 32'h8000_0000, 16'h0000);
    rd(REG_STICKY, 32'h0000_0400);
    fl(16'h0044, 32'h8000, 32'h8000, 32'h0, 16'h0400);
    fl(16'h00C4, 32'h8000, 32'h8000, 32'h1, 16'h0000);
    wr(REG_RESULT, 32'h1234);
    rd(REG_RESULT, 32'h1);
    fl(16'h0104, 32'h5, 32'h7, 32'h1, 16'h0000);
    rd(REG_FORE_LO, 32'h23);
    fl(16'h0105, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1, 16'h0200);
    rd(REG_FORE_LO, 32'h24);
    rd(REG_FORE_MID, 32'hFFFF_FFFE);
    rd(REG_FORE_HI, 32'h0);
    fl(16'h0205, 32'h2, 32'h3, 32'h6, 16'h0000);
    rd(REG_BACK_LO, 32'h0);
    rd(REG_CTRL, 32'h0205);
    fl(16'hFFFF, 32'h1, 32'h1, 32'h6, 16'h0000);
    rd(REG_CTRL, {16'h0, CTRL_MASK});
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(REG_FORE_MID, 32'h0);
    rd(REG_STICKY, {16'h0, STICKY_RESET});
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    give_verdict();
  end
endmodule
